//--- hdl/opt_pkg.sv
package opt_pkg;
  localparam logic [2:0] OPT_REG_CTRL = 3'h0;
  localparam logic [2:0] OPT_REG_TIMER = 3'h1;
  localparam logic [2:0] OPT_REG_STATUS = 3'h2;
  localparam logic [2:0] OPT_REG_MASK = 3'h3;
  localparam int OPT_STS_EVT = 0;
  localparam int OPT_STS_RUN = 1;
  localparam int OPT_STS_OUT = 2;
  localparam int OPT_STS_PIN = 3;
  localparam logic [15:0] OPT_TOP16 = 16'hfffe;
  localparam logic [15:0] OPT_TOP8 = 16'h00fe;
  localparam logic [4:0] OPT_DIV8_LAST = 5'h07;
  localparam logic [4:0] OPT_DIV32_LAST = 5'h1f;
  localparam logic [15:0] OPT_TIMER_RST = 16'h0000;
  localparam logic [31:0] OPT_RD_UNDEF = 32'h00000000;

  typedef enum logic [1:0]
  {
    OPT_CLK_F1 = 2'b00,
    OPT_CLK_F8 = 2'b01,
    OPT_CLK_F32 = 2'b10,
    OPT_CLK_SUBCLOCK_DIV32 = 2'b11
  } opt_clk_sel_t;

  typedef enum logic [1:0]
  {
    OPT_TRG_SW = 2'b00,
    OPT_TRG_FALL = 2'b01,
    OPT_TRG_RISE = 2'b10,
    OPT_TRG_OVF = 2'b11
  } opt_trg_t;

  typedef enum logic [1:0]
  {
    OPT_ST_IDLE = 2'b00,
    OPT_ST_ONESHOT = 2'b01,
    OPT_ST_PWM = 2'b10
  } opt_state_t;

  typedef struct packed
  {
    logic gpio_val;
    logic out_en;
    opt_trg_t trig_src;
    opt_clk_sel_t clk_sel;
    logic pwm8;
    logic mode_pwm;
    logic os_start;
    logic count_start;
  } opt_ctrl_t;

  localparam opt_ctrl_t OPT_CTRL_RST = '0;
endpackage

//--- hdl/opt_prescaler.sv
`timescale 1ns/10ps
module opt_prescaler
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_subclk_div32_src,
  input wire opt_pkg::opt_clk_sel_t i_sel,
  output logic o_tick
);
  import opt_pkg::*;

  logic [4:0] div_q;
  logic [4:0] sub_q;
  logic sub_prev_q;
  logic sub_rise;

  assign sub_rise = i_subclk_div32_src & ~sub_prev_q;

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      div_q <= '0;
      sub_q <= '0;
      sub_prev_q <= 1'b0;
    end
    else
    begin
      div_q <= div_q + 5'h01;
      sub_prev_q <= i_subclk_div32_src;
      if (sub_rise)
        sub_q <= sub_q + 5'h01;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      o_tick <= 1'b0;
    else
      unique case (i_sel)
        OPT_CLK_F1: o_tick <= 1'b1;
        OPT_CLK_F8: o_tick <= (div_q[2:0] == OPT_DIV8_LAST[2:0]);
        OPT_CLK_F32: o_tick <= (div_q == OPT_DIV32_LAST);
        OPT_CLK_SUBCLOCK_DIV32: o_tick <= sub_rise && (sub_q == OPT_DIV32_LAST);
      endcase
  end
endmodule

//--- hdl/opt_timer.sv
`timescale 1ns/10ps
module opt_timer
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [4:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  input wire logic i_trigger_input_pin,
  input wire logic i_subclk,
  input wire logic i_other_ovf,
  output logic o_pulse_output_pin,
  output logic o_irq
);
  import opt_pkg::*;

  function automatic logic [15:0] opt_merge
  (
    input logic [15:0] old,
    input logic [31:0] wd,
    input logic [3:0] be
  );
    logic [15:0] r;
    r = old;
    if (be[0])
      r[7:0] = wd[7:0];
    if (be[1])
      r[15:8] = wd[15:8];
    return r;
  endfunction

  opt_ctrl_t ctl_q;
  opt_state_t st_q;
  logic [15:0] reload_q;
  logic [15:0] cnt_q;
  logic [15:0] hi_q;
  logic [15:0] per_q;
  logic [7:0] pre_q;
  logic out_q;
  logic evt_q;
  logic [3:0] sts_q;
  logic [3:0] mask_q;
  logic [3:0] clr_q;
  logic trg_s1_q;
  logic trg_s2_q;
  logic trg_s3_q;
  logic sub_s1_q;
  logic sub_s2_q;
  logic tick;
  logic acc;
  logic [2:0] widx;
  logic wr_ctrl;
  logic wr_timer;
  logic [15:0] ctl_w;
  logic [15:0] tmr_w;
  logic os_go;
  logic trig_evt;
  logic start_os;
  logic start_pwm;
  logic [15:0] hw;
  logic [15:0] top;
  logic step;
  logic [15:0] per_n;
  logic [3:0] sts_live;
  logic [3:0] sts_d;

  // Pin synchronisers
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      trg_s1_q <= 1'b0;
      trg_s2_q <= 1'b0;
      trg_s3_q <= 1'b0;
      sub_s1_q <= 1'b0;
      sub_s2_q <= 1'b0;
    end
    else
    begin
      trg_s1_q <= i_trigger_input_pin;
      trg_s2_q <= trg_s1_q;
      trg_s3_q <= trg_s2_q;
      sub_s1_q <= i_subclk;
      sub_s2_q <= sub_s1_q;
    end
  end

  opt_prescaler u_pre
  (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_subclk_div32_src(sub_s2_q),
    .i_sel(ctl_q.clk_sel),
    .o_tick(tick)
  );

  // Bus access taken at the edge where waitrequest is low
  assign acc = (i_read | i_write) & ~o_waitrequest;
  assign widx = i_address[4:2];
  assign wr_ctrl = acc & i_write & (widx == OPT_REG_CTRL);
  assign wr_timer = acc & i_write & (widx == OPT_REG_TIMER);
  assign ctl_w = opt_merge(16'(ctl_q), i_writedata, i_byteenable);
  assign tmr_w = opt_merge(reload_q, i_writedata, i_byteenable);
  assign os_go = wr_ctrl & i_byteenable[0] & i_writedata[1];

  always_comb
  begin
    unique case (ctl_q.trig_src)
      OPT_TRG_SW: trig_evt = 1'b0;
      OPT_TRG_FALL: trig_evt = trg_s3_q & ~trg_s2_q;
      OPT_TRG_RISE: trig_evt = trg_s2_q & ~trg_s3_q;
      OPT_TRG_OVF: trig_evt = i_other_ovf;
    endcase
  end

  assign start_os = os_go | trig_evt;
  // PWM start on flag alone or on trigger
  assign start_pwm = (ctl_q.trig_src == OPT_TRG_SW) | trig_evt;

  // 8-bit width is high byte, low byte prescales
  assign hw = ctl_q.pwm8 ? {8'h00, hi_q[15:8]} : hi_q;
  assign top = ctl_q.pwm8 ? OPT_TOP8 : OPT_TOP16;
  assign step = tick & (~ctl_q.pwm8 | (pre_q == hi_q[7:0]));
  assign per_n = per_q + 16'h0001;

  // Control register
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      ctl_q <= OPT_CTRL_RST;
    else if (wr_ctrl)
    begin
      ctl_q <= opt_ctrl_t'(ctl_w[9:0]);
      ctl_q.os_start <= 1'b0;
    end
  end

  // Reload register takes every timer write
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      reload_q <= OPT_TIMER_RST;
    else if (wr_timer)
      reload_q <= tmr_w;
  end

  // Counting core
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      st_q <= OPT_ST_IDLE;
      cnt_q <= OPT_TIMER_RST;
      hi_q <= OPT_TIMER_RST;
      per_q <= '0;
      pre_q <= '0;
      out_q <= 1'b0;
      evt_q <= 1'b0;
    end
    else
    begin
      evt_q <= 1'b0;
      if (wr_timer && st_q == OPT_ST_IDLE)
      begin
        cnt_q <= tmr_w;
        hi_q <= tmr_w;
      end
      if (!ctl_q.count_start)
      begin
        st_q <= OPT_ST_IDLE;
        out_q <= 1'b0;
      end
      else
      begin
        unique case (st_q)
          OPT_ST_IDLE:
          begin
            if (ctl_q.mode_pwm && start_pwm)
            begin
              st_q <= OPT_ST_PWM;
              hi_q <= reload_q;
              per_q <= '0;
              pre_q <= '0;
              out_q <= ctl_q.pwm8 ? (reload_q[15:8] != 8'h00)
                                  : (reload_q != 16'h0000);
            end
            else if (!ctl_q.mode_pwm && start_os)
            begin
              st_q <= OPT_ST_ONESHOT;
              cnt_q <= reload_q;
              out_q <= 1'b1;
            end
          end
          OPT_ST_ONESHOT:
          begin
            if (start_os)
            begin
              cnt_q <= reload_q;
            end
            else if (tick)
            begin
              if (cnt_q <= 16'h0001)
              begin
                cnt_q <= reload_q;
                st_q <= OPT_ST_IDLE;
                out_q <= 1'b0;
                evt_q <= 1'b1;
              end
              else
                cnt_q <= cnt_q - 16'h0001;
            end
          end
          OPT_ST_PWM:
          begin
            if (tick)
              pre_q <= step ? 8'h00 : pre_q + 8'h01;
            if (step)
            begin
              if (per_q == top)
              begin
                per_q <= '0;
                hi_q <= reload_q;
                out_q <= ctl_q.pwm8 ? (reload_q[15:8] != 8'h00)
                                    : (reload_q != 16'h0000);
              end
              else
              begin
                per_q <= per_n;
                if (out_q && per_n == hw)
                begin
                  out_q <= 1'b0;
                  evt_q <= 1'b1;
                end
              end
            end
          end
          default:
            st_q <= OPT_ST_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      o_pulse_output_pin <= 1'b0;
    else if (ctl_q.mode_pwm || ctl_q.out_en)
      o_pulse_output_pin <= out_q;
    else
      o_pulse_output_pin <= ctl_q.gpio_val;
  end

  // Status: event sticky, set wins over read clear
  assign sts_live = {trg_s2_q, out_q, st_q != OPT_ST_IDLE, 1'b0};
  always_comb
  begin
    sts_d = sts_q;
    if (acc && i_read && widx == OPT_REG_STATUS)
      sts_d = sts_d & ~clr_q;
    if (evt_q)
      sts_d[OPT_STS_EVT] = 1'b1;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      sts_q <= '0;
    else
      sts_q <= sts_d;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      mask_q <= '0;
    else if (acc && i_write && widx == OPT_REG_MASK && i_byteenable[0])
      mask_q <= i_writedata[3:0];
  end

  // Level interrupt
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      o_irq <= 1'b0;
    else
      o_irq <= |(sts_d & mask_q & 4'h1);
  end

  // Bus slave: one wait cycle, data prepared before the taking edge
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_waitrequest <= 1'b1;
      o_readdata <= '0;
      clr_q <= '0;
    end
    else if (acc)
      o_waitrequest <= 1'b1;
    else if (i_read || i_write)
    begin
      o_waitrequest <= 1'b0;
      clr_q <= sts_q;
      unique case (widx)
        OPT_REG_CTRL: o_readdata <= {22'h0, ctl_q};
        OPT_REG_TIMER: o_readdata <= OPT_RD_UNDEF;
        OPT_REG_STATUS: o_readdata <= {28'h0, sts_q | sts_live};
        OPT_REG_MASK: o_readdata <= {28'h0, mask_q};
        default: o_readdata <= '0;
      endcase
    end
  end
endmodule

//--- sim/opt_checker.sv
`timescale 1ns/10ps
module opt_checker
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [4:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [31:0] o_readdata,
  input wire logic o_waitrequest,
  input wire logic o_pulse_output_pin,
  input wire logic o_irq
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  logic acc;
  logic ctl;
  assign acc = (i_read || i_write) && !o_waitrequest;
  assign ctl = acc && i_write && i_address[4:2] == 3'h0;
  a_wait_answer: assert property (
    (i_read || i_write) && o_waitrequest |=> !o_waitrequest)
    else $error("request not answered");
  a_wait_once: assert property (
    !o_waitrequest |=> o_waitrequest)
    else $error("wait low too long");
  a_no_spurious: assert property (
    !(i_read || i_write) |=> o_waitrequest)
    else $error("answer without request");
  a_stable_rdata: assert property (
    o_waitrequest |-> $stable(o_readdata))
    else $error("read data moved");
  a_undef_read: assert property (
    acc && i_read && (i_address[4:2] == 3'h1 || i_address[4])
    |-> o_readdata == 32'h0)
    else $error("timer read not zero");
  a_stop_low: assert property (
    ctl && !i_writedata[0] && i_writedata[8]
    |-> ##3 !o_pulse_output_pin [*2])
    else $error("pin high after stop");
  a_gpio_high: assert property (
    ctl && i_writedata[9:8] == 2'h2 && !i_writedata[2]
    |-> ##3 o_pulse_output_pin [*2])
    else $error("gpio value not driven");
  a_os_start: assert property (
    ctl && i_writedata[1:0] == 2'h3 && i_writedata[8] && !i_writedata[2]
    |-> ##[1:4] o_pulse_output_pin)
    else $error("one-shot did not start");
  a_pwm_no_gpio: assert property (
    ctl && i_writedata[2] && !i_writedata[0] && i_writedata[9]
    |-> ##3 !o_pulse_output_pin [*2])
    else $error("gpio leaks in pwm");
  c_pulse_end: cover property ($fell(o_pulse_output_pin));
  c_irq_up: cover property ($rose(o_irq));
  c_unmapped: cover property (acc && i_read && i_address[4]);
endmodule

bind opt_timer opt_checker u_chk
(
  .i_clk(i_clk),
  .i_sys_rst(i_sys_rst),
  .i_address(i_address),
  .i_read(i_read),
  .i_write(i_write),
  .i_writedata(i_writedata),
  .o_readdata(o_readdata),
  .o_waitrequest(o_waitrequest),
  .o_pulse_output_pin(o_pulse_output_pin),
  .o_irq(o_irq)
);

//--- sim/opt_partner.sv
`timescale 1ns/10ps
module opt_partner
(
  input wire logic i_clk,
  input wire logic i_pulse,
  output logic o_trig,
  output logic o_ovf,
  output int o_high,
  output int o_period
);
  int hc = 0;
  int pc = 0;
  int hw = 0;
  int per = 0;
  logic prev = 1'h0;
  logic trig_q = 1'h0;
  logic ovf_q = 1'h0;
  assign o_trig = trig_q;
  assign o_ovf = ovf_q;
  assign o_high = hw;
  assign o_period = per;
  // Load: last high width and rise-to-rise period
  always @(posedge i_clk)
  begin
    prev <= i_pulse;
    hc <= i_pulse ? hc + 1 : 0;
    pc <= (i_pulse && !prev) ? 1 : pc + 1;
    if (!i_pulse && prev)
      hw <= hc;
    if (i_pulse && !prev)
      per <= pc;
  end
  task automatic pin_pulse;
    @(posedge i_clk);
    trig_q <= 1'h1;
    repeat (4) @(posedge i_clk);
    trig_q <= 1'h0;
  endtask
  task automatic ovf_pulse;
    @(posedge i_clk);
    ovf_q <= 1'h1;
    @(posedge i_clk);
    ovf_q <= 1'h0;
  endtask
endmodule

//--- sim/tb_top.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
  $display("FAIL %s exp %0h got %0h", n, e, g); end end
module tb_top;
  logic i_clk = 1'h0;
  logic i_sys_rst = 1'h1;
  logic [4:0] i_address = 5'h0;
  logic i_read = 1'h0;
  logic i_write = 1'h0;
  logic [31:0] i_writedata = 32'h0;
  logic i_subclk = 1'h0;
  logic [31:0] o_readdata;
  logic [31:0] q;
  logic o_waitrequest;
  logic pin;
  logic o_irq;
  logic trig;
  logic ovf;
  int hi;
  int per;
  int err_total = 0;
  int compares = 0;
  always #25 i_clk = ~i_clk;
  always @(posedge i_clk) i_subclk <= ~i_subclk;
  opt_timer DUT(.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_address(i_address),
    .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
    .i_byteenable(4'h3), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .i_trigger_input_pin(trig),
    .i_subclk(i_subclk), .i_other_ovf(ovf), .o_pulse_output_pin(pin),
    .o_irq(o_irq));
  opt_partner u_far(.i_clk(i_clk), .i_pulse(pin), .o_trig(trig),
    .o_ovf(ovf), .o_high(hi), .o_period(per));
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_write <= w;
    i_read <= !w;
    i_address <= a;
    i_writedata <= d;
    do
    begin
      @(posedge i_clk);
    end
    while (o_waitrequest !== 1'h0);
    q = o_readdata;
    i_write <= 1'h0;
    i_read <= 1'h0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask
  task automatic rd(input logic [4:0] a);
    bus(1'h0, a, 32'h0);
  endtask
  task automatic end_sim;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic t_regs;
    wr(5'h04, 32'h0000abcd);
    rd(5'h04);
    `CHK("timer_rd", 32'h0, q)
    wr(5'h14, 32'hffffffff);
    rd(5'h10);
    `CHK("unmapped", 32'h0, q)
    wr(5'h00, 32'h200);
    repeat (3) @(posedge i_clk);
    `CHK("gpio", 1'h1, pin)
  endtask
  task automatic t_oneshot;
    wr(5'h04, 32'h5);
    wr(5'h0c, 32'h1);
    wr(5'h00, 32'h101);
    wr(5'h00, 32'h103);
    repeat (20) @(posedge i_clk);
    `CHK("os_high", 5, hi)
    `CHK("irq", 1'h1, o_irq)
    rd(5'h08);
    `CHK("status", 2'h1, q[1:0])
    rd(5'h08);
    `CHK("evt_clr", 2'h0, {q[0], o_irq})
    wr(5'h0c, 32'h0);
    wr(5'h00, 32'h103);
    repeat (20) @(posedge i_clk);
    `CHK("irq_mask", 1'h0, o_irq)
    rd(5'h08);
    `CHK("evt_mask", 1'h1, q[0])
  endtask
  task automatic t_trig;
    wr(5'h04, 32'h14);
    wr(5'h00, 32'h181);
    u_far.pin_pulse();
    repeat (10) @(posedge i_clk);
    u_far.pin_pulse();
    repeat (50) @(posedge i_clk);
    `CHK("retrig", 1'h1, hi > 30)
    wr(5'h04, 32'h3);
    wr(5'h00, 32'h1c1);
    u_far.ovf_pulse();
    repeat (20) @(posedge i_clk);
    `CHK("ovf_os", 3, hi)
    wr(5'h04, 32'h4);
    wr(5'h00, 32'h141);
    u_far.pin_pulse();
    repeat (2) @(posedge i_clk);
    `CHK("fall_wait", 1'h0, pin)
    repeat (20) @(posedge i_clk);
    `CHK("fall_os", 4, hi)
  endtask
  task automatic t_pwm;
    wr(5'h04, 32'h0201);
    wr(5'h00, 32'h18d);
    rd(5'h08);
    repeat (20) @(posedge i_clk);
    `CHK("pwm_wait", 1'h0, pin)
    u_far.pin_pulse();
    repeat (1100) @(posedge i_clk);
    `CHK("pwm8_hi", 4, hi)
    `CHK("pwm8_per", 510, per)
    wr(5'h04, 32'h0301);
    u_far.pin_pulse();
    repeat (600) @(posedge i_clk);
    `CHK("pwm8_new", 6, hi)
    `CHK("pwm8_trig", 510, per)
    rd(5'h08);
    `CHK("pwm_evt", 1'h1, q[0])
    wr(5'h00, 32'h38c);
    wr(5'h04, 32'h3);
    wr(5'h00, 32'h105);
    repeat (65600) @(posedge i_clk);
    `CHK("pwm16_hi", 3, hi)
    `CHK("pwm16_per", 65535, per)
  endtask
  task automatic t_clk;
    int dv;
    for (int s = 1; s < 4; s++)
    begin
      dv = (s == 1) ? 8 : (s == 2) ? 32 : 64;
      wr(5'h00, 32'h0);
      wr(5'h04, 32'h2);
      wr(5'h00, 32'h101 | (s << 4));
      wr(5'h00, 32'h103 | (s << 4));
      repeat (2 * dv + 40) @(posedge i_clk);
      `CHK("div", 1'h1, hi >= dv && hi <= 2 * dv + 2)
    end
  endtask
  initial
  begin
    repeat (80000) @(posedge i_clk);
    err_total++;
    end_sim();
  end
  initial
  begin
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'h0;
    t_regs();
    t_oneshot();
    t_trig();
    t_pwm();
    t_clk();
    end_sim();
  end
endmodule
